// ---- src/energy_trim_top.v ----
// active energy gain/offset trim, line-cycle accumulation, apb registers
// assumes active_power and apparent_power come from logic on pclk;
// zero_cross_in is a pin and is synchronised here
`timescale 1ns/1ps
`include "energy_trim_defines.vh"

module energy_trim_top #(
	parameter PULSE_W = 16
) (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [23:0] active_power,
	input wire [23:0] apparent_power,
	input wire zero_cross_in,
	output wire energy_pulse_out,
	output reg irq_out,
	output reg irq_oe_n
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [1:0] mode_q;
	reg [11:0] watt_gain_trim_q;
	reg [15:0] active_power_offset_q;
	reg [11:0] pulse_ratio_numerator_q;
	reg [11:0] pulse_ratio_denominator_q;
	reg [7:0] energy_divider_q;
	reg [15:0] half_cycle_count_q;
	reg [23:0] active_energy_accum_q;
	reg [23:0] line_cycle_active_energy_q;
	reg [23:0] line_cycle_apparent_energy_q;
	reg [15:0] period_q;
	reg stat_q;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire setup = psel & ~penable;
	wire wr_done = psel & penable & pwrite & pready;
	reg [31:0] rd_mux;
	reg hit;

	always @* begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			`ADDR_MODE: rd_mux = {30'h0, mode_q};
			`ADDR_GAIN: rd_mux = {20'h0, watt_gain_trim_q};
			`ADDR_ACTIVE_POWER_OFFSET: rd_mux = {16'h0, active_power_offset_q};
			`ADDR_NUM: rd_mux = {20'h0, pulse_ratio_numerator_q};
			`ADDR_DEN: rd_mux = {20'h0, pulse_ratio_denominator_q};
			`ADDR_ENERGY_DIVIDER: rd_mux = {24'h0, energy_divider_q};
			`ADDR_HALF: rd_mux = {16'h0, half_cycle_count_q};
			`ADDR_ACTIVE_ENERGY_ACCUM: rd_mux = {8'h0, active_energy_accum_q};
			`ADDR_LINE_CYCLE_ACTIVE_ENERGY: rd_mux = {8'h0, line_cycle_active_energy_q};
			`ADDR_LINE_CYCLE_APPARENT_ENERGY: rd_mux = {8'h0, line_cycle_apparent_energy_q};
			`ADDR_PERIOD: rd_mux = {16'h0, period_q};
			`ADDR_STATUS: rd_mux = {31'h0, stat_q};
			default: hit = 1'b0;
		endcase
	end

	// answer one cycle after a setup seen with clk_en high, so such an access phase lasts one cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			pready <= setup;
			pslverr <= setup & ~hit;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	wire wr_ok = wr_done & ~pslverr;
	wire clr_stat = wr_ok & (paddr == `ADDR_STATUS) & pwdata[`STAT_LINE_BIT];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= `RST_MODE;
			watt_gain_trim_q <= `RST_GAIN;
			active_power_offset_q <= `RST_ACTIVE_POWER_OFFSET;
			pulse_ratio_numerator_q <= `RST_NUM;
			pulse_ratio_denominator_q <= `RST_DEN;
			energy_divider_q <= `RST_ENERGY_DIVIDER;
			half_cycle_count_q <= `RST_HALF;
		end else if (clk_en && wr_ok) begin
			case (paddr)
				`ADDR_MODE: mode_q <= pwdata[1:0];
				`ADDR_GAIN: watt_gain_trim_q <= pwdata[11:0];
				`ADDR_ACTIVE_POWER_OFFSET: active_power_offset_q <= pwdata[15:0];
				`ADDR_NUM: pulse_ratio_numerator_q <= pwdata[11:0];
				`ADDR_DEN: pulse_ratio_denominator_q <= pwdata[11:0];
				`ADDR_ENERGY_DIVIDER: energy_divider_q <= pwdata[7:0];
				`ADDR_HALF: half_cycle_count_q <= pwdata[15:0];
				default: mode_q <= mode_q;
			endcase
		end
	end

	// ----------------------------------------
	// accumulation tick and zero-cross sync
	// ----------------------------------------
	reg [1:0] tick_cnt_q;
	reg zx_s1_q;
	reg zx_s2_q;
	reg zx_s3_q;
	wire tick = clk_en & (tick_cnt_q == `TICK_LAST);
	wire zx_edge = clk_en & (zx_s2_q ^ zx_s3_q);
	wire zx_rise = clk_en & zx_s2_q & ~zx_s3_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 2'h0;
			zx_s1_q <= 1'b0;
			zx_s2_q <= 1'b0;
			zx_s3_q <= 1'b0;
		end else if (clk_en) begin
			tick_cnt_q <= tick_cnt_q + 2'h1;
			zx_s1_q <= zero_cross_in;
			zx_s2_q <= zx_s1_q;
			zx_s3_q <= zx_s2_q;
		end
	end

	// ----------------------------------------
	// line period in units of eight clocks
	// ----------------------------------------
	reg [2:0] unit_cnt_q;
	reg [15:0] per_cnt_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_cnt_q <= 3'h0;
			per_cnt_q <= 16'h0000;
			period_q <= 16'h0000;
		end else if (clk_en) begin
			unit_cnt_q <= zx_rise ? 3'h0 : unit_cnt_q + 3'h1;
			if (zx_rise) begin
				period_q <= per_cnt_q;
				per_cnt_q <= 16'h0000;
			end else if (unit_cnt_q == `PERIOD_UNIT_LAST && per_cnt_q != 16'hffff) begin
				per_cnt_q <= per_cnt_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// gain and offset trim
	// ----------------------------------------
	// unity is 4096, so one trim lsb is 1/4096 (0.0244 percent)
	wire signed [14:0] gain_f = $signed(`GAIN_UNITY) +
		$signed({{3{watt_gain_trim_q[11]}}, watt_gain_trim_q});
	wire signed [38:0] prod = $signed(active_power) * gain_f;
	wire [25:0] p_trim = prod[37:12];
	// power enters above 8 fractional bits; offset adds at the fraction
	wire [57:0] add_w = {{24{p_trim[25]}}, p_trim, 8'h00} +
		{{42{active_power_offset_q[15]}}, active_power_offset_q};
	reg [57:0] fine_q;
	wire [57:0] fine_d = fine_q + add_w;
	// bit 33 of the fine sum is the energy lsb; per tick the carry is at most one
	wire [24:0] hi_old = fine_q[57:`ENERGY_LSB_POS];
	wire [24:0] hi_new = fine_d[57:`ENERGY_LSB_POS];
	wire step_up = tick & ($signed(hi_new) > $signed(hi_old));
	wire step_dn = tick & ($signed(hi_new) < $signed(hi_old));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fine_q <= 58'h0;
		end else if (tick) begin
			fine_q <= fine_d;
		end
	end

	// ----------------------------------------
	// energy divider
	// ----------------------------------------
	reg signed [9:0] div_cnt_q;
	wire signed [9:0] div_lim = (energy_divider_q == 8'h00) ? 10'sd1 :
		$signed({2'b00, energy_divider_q});
	wire signed [9:0] div_up = div_cnt_q + 10'sd1;
	wire signed [9:0] div_dn = div_cnt_q - 10'sd1;
	wire e_inc = step_up & (div_up >= div_lim);
	wire e_dec = step_dn & (-div_dn >= div_lim);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= 10'sd0;
			active_energy_accum_q <= 24'h000000;
		end else if (clk_en) begin
			if (step_up) begin
				div_cnt_q <= e_inc ? 10'sd0 : div_up;
			end else if (step_dn) begin
				div_cnt_q <= e_dec ? 10'sd0 : div_dn;
			end
			if (e_inc) begin
				active_energy_accum_q <= active_energy_accum_q + 24'h000001;
			end else if (e_dec) begin
				active_energy_accum_q <= active_energy_accum_q - 24'h000001;
			end
		end
	end

	// undivided energy steps drive the pulse chain
	pulse_ratio_gen #(
		.PULSE_W(PULSE_W)
	) u_pulse (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.energy_up(step_up),
		.ratio_num(pulse_ratio_numerator_q),
		.ratio_den(pulse_ratio_denominator_q),
		.pulse_out(energy_pulse_out)
	);

	// ----------------------------------------
	// line-cycle accumulation
	// ----------------------------------------
	reg [15:0] half_cnt_q;
	reg [15:0] half_target_q;
	reg [23:0] line_act_q;
	reg [57:0] line_app_q;
	wire line_mode = mode_q[`MODE_LINE_BIT];
	wire [15:0] half_next = half_cnt_q + 16'h0001;
	wire line_end = line_mode & zx_edge & (half_next >= half_target_q);
	wire [57:0] app_add = {26'h0, apparent_power, 8'h00};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt_q <= 16'h0000;
			half_target_q <= `RST_HALF;
			line_act_q <= 24'h000000;
			line_app_q <= 58'h0;
			line_cycle_active_energy_q <= 24'h000000;
			line_cycle_apparent_energy_q <= 24'h000000;
		end else if (clk_en) begin
			if (!line_mode) begin
				// the count is taken up only at an interval start
				half_cnt_q <= 16'h0000;
				half_target_q <= half_cycle_count_q;
				line_act_q <= 24'h000000;
				line_app_q <= 58'h0;
			end else if (line_end) begin
				line_cycle_active_energy_q <= line_act_q;
				line_cycle_apparent_energy_q <= line_app_q[56:`ENERGY_LSB_POS];
				half_cnt_q <= 16'h0000;
				half_target_q <= half_cycle_count_q;
				line_act_q <= 24'h000000;
				line_app_q <= 58'h0;
			end else begin
				if (zx_edge) begin
					half_cnt_q <= half_next;
				end
				if (e_inc) begin
					line_act_q <= line_act_q + 24'h000001;
				end else if (e_dec) begin
					line_act_q <= line_act_q - 24'h000001;
				end
				if (tick) begin
					line_app_q <= line_app_q + app_add;
				end
			end
		end
	end

	// ----------------------------------------
	// status and interrupt pin
	// ----------------------------------------
	// a completion in the clearing cycle keeps the flag set
	wire stat_d = line_end | (stat_q & ~clr_stat);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= 1'b0;
			irq_out <= 1'b0;
			irq_oe_n <= 1'b1;
		end else if (clk_en) begin
			stat_q <= stat_d;
			irq_out <= 1'b0;
			irq_oe_n <= ~(stat_d & mode_q[`MODE_LIEN_BIT]);
		end
	end

endmodule // energy_trim_top

// ---- shared/energy_trim_defines.vh ----
// constants for the active energy trim datapath and its apb register map
// assumes 32-bit apb data, byte addresses on an 8-bit paddr
`ifndef ENERGY_TRIM_DEFINES_VH
`define ENERGY_TRIM_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADDR_MODE 8'h00
`define ADDR_GAIN 8'h04
`define ADDR_ACTIVE_POWER_OFFSET 8'h08
`define ADDR_NUM 8'h0c
`define ADDR_DEN 8'h10
`define ADDR_ENERGY_DIVIDER 8'h14
`define ADDR_HALF 8'h18
`define ADDR_ACTIVE_ENERGY_ACCUM 8'h1c
`define ADDR_LINE_CYCLE_ACTIVE_ENERGY 8'h20
`define ADDR_LINE_CYCLE_APPARENT_ENERGY 8'h24
`define ADDR_PERIOD 8'h28
`define ADDR_STATUS 8'h2c

// ----------------------------------------
// field positions
// ----------------------------------------
`define MODE_LINE_BIT 0
`define MODE_LIEN_BIT 1
`define STAT_LINE_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_MODE 2'h0
`define RST_GAIN 12'h000
`define RST_ACTIVE_POWER_OFFSET 16'h0000
`define RST_NUM 12'h03f
`define RST_DEN 12'h03f
`define RST_ENERGY_DIVIDER 8'h00
`define RST_HALF 16'hffff

// ----------------------------------------
// datapath scaling and timing counts
// ----------------------------------------
`define TICK_LAST 2'h3
`define PERIOD_UNIT_LAST 3'h7
`define GAIN_UNITY 15'h1000
`define ENERGY_LSB_POS 33

`endif

// ---- src/pulse_ratio_gen.v ----
// pulse generator: one output pulse per (den+1)/(num+1) energy steps
// assumes energy_up is a one-cycle strobe on pclk, at most one per cycle
`timescale 1ns/1ps

module pulse_ratio_gen #(
	parameter PULSE_W = 16
) (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire energy_up,
	input wire [11:0] ratio_num,
	input wire [11:0] ratio_den,
	output reg pulse_out
);

	// ----------------------------------------
	// ratio accumulator
	// ----------------------------------------
	// sized copy so the width load is an explicit part-select
	localparam [31:0] PULSE_W32 = PULSE_W;
	reg [13:0] acc_q;
	reg [15:0] width_q;
	wire [13:0] step = {2'h0, ratio_num} + 14'h0001;
	wire [13:0] lim = {2'h0, ratio_den} + 14'h0001;
	wire [14:0] sum = {1'b0, acc_q} + (energy_up ? {1'b0, step} : 15'h0000);
	// saturate so a ratio above one cannot wrap while pulses drain
	wire [13:0] acc_d = sum[14] ? 14'h3fff : sum[13:0];
	wire fire = (acc_d >= lim);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 14'h0000;
			width_q <= 16'h0000;
			pulse_out <= 1'b0;
		end else if (clk_en) begin
			acc_q <= fire ? acc_d - lim : acc_d;
			if (fire) begin
				width_q <= PULSE_W32[15:0];
				pulse_out <= 1'b1;
			end else if (width_q > 16'h0001) begin
				width_q <= width_q - 16'h0001;
			end else begin
				width_q <= 16'h0000;
				pulse_out <= 1'b0;
			end
		end
	end

endmodule // pulse_ratio_gen

// ---- tb/energy_trim_top_properties.sv ----
// checker for energy_trim_top port timing
// assumes one pclk domain, bound to every energy_trim_top
`timescale 1ns/1ps

module energy_trim_props #(
	parameter PULSE_W = 16
) (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire energy_pulse_out,
	input wire irq_out,
	input wire irq_oe_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// high-time counter, a repetition cannot take the parameter
	reg [15:0] hi_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hi_q <= 16'h0000;
		else if (clk_en)
			hi_q <= energy_pulse_out ? hi_q + 16'h0001 : 16'h0000;
	end
	sequence setup_s;
		psel && !penable && clk_en;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	a_ready_after_setup: assert property (setup_s |=> answer_s) else $error("no answer");
	a_ready_needs_setup: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_err_data_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
	a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("rdata moved");
	a_pulse_width: assert property ($fell(energy_pulse_out) |-> hi_q == PULSE_W) else $error("pulse width");
	a_pulse_max: assert property (hi_q <= PULSE_W) else $error("pulse too long");
	a_irq_low_data: assert property (!irq_out) else $error("irq data high");
	a_irq_sticky: assert property (!irq_oe_n && !(psel && pwrite) |=> !irq_oe_n) else $error("irq dropped");
endmodule // energy_trim_props

bind energy_trim_top energy_trim_props #(.PULSE_W(PULSE_W)) props_i (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .energy_pulse_out(energy_pulse_out),
	.irq_out(irq_out), .irq_oe_n(irq_oe_n));

// ---- tb/line_zero_cross_src.sv ----
// zero-cross square wave standing in for the line voltage
// assumes the bench clock and reset; toggles every HALF cycles
`timescale 1ns/1ps

module line_zero_cross_src #(
	parameter int HALF = 256
) (
	input wire pclk,
	input wire presetn,
	output reg zero_cross_in
);
	int cnt_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			zero_cross_in <= 1'b0;
		end else if (cnt_q == HALF - 1) begin
			cnt_q <= 0;
			zero_cross_in <= ~zero_cross_in;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule // line_zero_cross_src

// ---- tb/tb_energy_trim_top.sv ----
// self-checking bench for energy_trim_top, host role over apb
// assumes the zero-cross partner and the bound checker
`timescale 1ns/1ps
`include "energy_trim_defines.vh"

module tb_energy_trim_top;
	localparam int HALF = 256;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg clk_en = 1'b1;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	// power 2^22 keeps an energy step every eight ticks
	reg [23:0] active_power = 24'h400000;
	reg [23:0] apparent_power = 24'h400000;
	wire [31:0] prdata;
	wire pready, pslverr, energy_pulse_out, irq_out, irq_oe_n, zero_cross_in;
	int n_errors = 0;
	int check_count = 0;
	int pulses = 0;
	reg pulse_q = 1'b0;
	reg [31:0] rd;
	reg err;
	reg [31:0] le;
	reg [31:0] lva;
	int p0 = 0;

	energy_trim_top #(.PULSE_W(4)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .active_power(active_power),
		.apparent_power(apparent_power), .zero_cross_in(zero_cross_in),
		.energy_pulse_out(energy_pulse_out), .irq_out(irq_out), .irq_oe_n(irq_oe_n));
	line_zero_cross_src #(.HALF(HALF)) line_i (.pclk(pclk), .presetn(presetn),
		.zero_cross_in(zero_cross_in));

	initial forever #4 pclk = ~pclk;
	always @(posedge pclk) begin
		pulse_q <= energy_pulse_out;
		if (energy_pulse_out === 1'b1 && pulse_q === 1'b0)
			pulses <= pulses + 1;
	end

	task report_and_stop;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string w, input logic [31:0] e, input logic [31:0] g, input int t);
		check_count++;
		if (((g + t >= e) && (g <= e + t)) !== 1'b1) begin
			n_errors++;
			$display("[FAIL] %s expected %0d seen %0d", w, e, g);
		end
	endtask
	task apb(input reg wr, input reg [7:0] a, input reg [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	task wait_irq;
		int i;
		// step first: the pin still shows its pre-clear level in the return step
		for (i = 0; i < 5000; i++) begin
			@(posedge pclk);
			if (irq_oe_n === 1'b0)
				break;
		end
		if (i == 5000) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	// first interval after any change is thrown away
	task line_run;
		apb(1'b1, `ADDR_STATUS, 32'h1);
		wait_irq();
		apb(1'b1, `ADDR_STATUS, 32'h1);
		p0 = pulses;
		wait_irq();
		apb(1'b0, `ADDR_LINE_CYCLE_ACTIVE_ENERGY, 32'h0);
		le = rd;
		apb(1'b0, `ADDR_LINE_CYCLE_APPARENT_ENERGY, 32'h0);
		lva = rd;
	endtask

	task t_regs;
		reg [7:0] a[4] = '{`ADDR_HALF, `ADDR_NUM, `ADDR_DEN, `ADDR_MODE};
		reg [31:0] e[4] = '{32'h0000ffff, 32'h3f, 32'h3f, 32'h0};
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, a[k], 32'h0);
			chk("reset value", e[k], rd, 0);
		end
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err}, 0);
		chk("unmapped data", 32'h0, rd, 0);
		apb(1'b1, `ADDR_GAIN, 32'h800);
		apb(1'b0, `ADDR_GAIN, 32'h0);
		chk("gain field", 32'h800, rd, 0);
	endtask
	task t_setup;
		apb(1'b1, `ADDR_NUM, 32'h0);
		apb(1'b1, `ADDR_DEN, 32'h1);
		apb(1'b1, `ADDR_HALF, 32'h4);
		apb(1'b1, `ADDR_MODE, 32'h3);
	endtask
	// four half cycles of HALF clocks give HALF ticks of four clocks
	task t_gain;
		int g[4] = '{0, -2048, 2047, 126};
		longint e;
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `ADDR_GAIN, 32'(g[k]) & 32'hfff);
			line_run();
			e = ((longint'(HALF) * (4096 + g[k])) << 30) >> 45;
			chk("line energy", 32'(e), le, 1);
			chk("pulses", 32'(e / 2), 32'(pulses - p0), 1);
			chk("line apparent", 32'(HALF / 8), lva, 1);
		end
	endtask
	task t_energy_divider;
		apb(1'b1, `ADDR_GAIN, 32'h0);
		apb(1'b1, `ADDR_ENERGY_DIVIDER, 32'h2);
		line_run();
		chk("divided energy", 32'(HALF / 16), le, 1);
		chk("divided pulses", 32'(HALF / 16), 32'(pulses - p0), 1);
		apb(1'b1, `ADDR_ENERGY_DIVIDER, 32'h0);
	endtask
	task t_irq;
		repeat (50) @(posedge pclk);
		chk("irq held", 32'h0, {31'h0, irq_oe_n}, 0);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk("status set", 32'h1, rd & 32'h1, 0);
		apb(1'b1, `ADDR_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq released", 32'h1, {31'h0, irq_oe_n}, 0);
	endtask
	task t_period;
		apb(1'b0, `ADDR_PERIOD, 32'h0);
		chk("period", 32'(HALF / 4), rd, 1);
	endtask
	// mid-run reset clears the fine sum, so offset carries are exact
	task t_offset;
		active_power <= 24'h000000;
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("reset irq pin", 32'h1, {31'h0, irq_oe_n}, 0);
		chk("reset rdata", 32'h0, prdata, 0);
		apb(1'b0, `ADDR_ACTIVE_ENERGY_ACCUM, 32'h0);
		chk("energy after reset", 32'h0, rd, 0);
		apb(1'b1, `ADDR_ACTIVE_POWER_OFFSET, 32'hffff);
		repeat (20) @(posedge pclk);
		apb(1'b0, `ADDR_ACTIVE_ENERGY_ACCUM, 32'h0);
		chk("negative offset", 32'hffffff, rd, 0);
		apb(1'b1, `ADDR_ACTIVE_POWER_OFFSET, 32'h100);
		repeat (100) @(posedge pclk);
		// power of minus one lsb is cancelled by an offset of 256
		active_power <= 24'hffffff;
		repeat (200) @(posedge pclk);
		apb(1'b0, `ADDR_ACTIVE_ENERGY_ACCUM, 32'h0);
		chk("offset cancels power", 32'h0, rd, 0);
		apb(1'b1, `ADDR_ACTIVE_POWER_OFFSET, 32'h0);
		clk_en <= 1'b0;
		repeat (400) @(posedge pclk);
		chk("frozen answer", 32'h0, {31'h0, pready}, 0);
		clk_en <= 1'b1;
		apb(1'b0, `ADDR_ACTIVE_ENERGY_ACCUM, 32'h0);
		chk("frozen energy", 32'h0, rd, 0);
		repeat (400) @(posedge pclk);
		apb(1'b0, `ADDR_ACTIVE_ENERGY_ACCUM, 32'h0);
		chk("offset removed", 32'hffffff, rd, 0);
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_setup();
		t_gain();
		t_energy_divider();
		t_irq();
		t_period();
		t_offset();
		report_and_stop();
	end
endmodule // tb_energy_trim_top
